// ==== common/thermal_clock_throttle_pkg.sv ====
/*
 * Constants for the core clock throttle: control register layout, reset value,
 * modulation timing, force pulse and hysteresis times.
 * Assumes a single 25 MHz core clock; every count is derived from it here.
 */
package thermal_clock_throttle_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int MAX_OFF_TIME_NS = 3000;
    // Longest time rounds down
    localparam int MAX_OFF_CYC = MAX_OFF_TIME_NS / CLK_PERIOD_NS;
    localparam int MOD_SLOTS = 8;
    // Slot so that even seven off slots stay under the off limit
    localparam int SLOT_CYC = MAX_OFF_CYC / MOD_SLOTS;
    localparam int FORCE_MIN_TIME_US = 500;
    localparam int FORCE_MIN_CYC = FORCE_MIN_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int HYST_TIME_US = 1000;
    localparam int HYST_CYC_DEFAULT = HYST_TIME_US * 1000 / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // Clock modulation control register
    // ---------------------------------------------------------------
    localparam int CMC_WIDTH = 64;
    localparam int CMC_ENABLE_BIT = 4;
    localparam int CMC_DUTY_LSB = 1;
    localparam int CMC_DUTY_W = 3;
    localparam logic [CMC_WIDTH-1:0] CMC_RESET = 64'h0000_0000_0000_0000;
    localparam logic [CMC_DUTY_W-1:0] DUTY_RESERVED = 3'h0;

    // Factory on-slots out of eight: 3/8 on, fixed at manufacture
    localparam logic [CMC_DUTY_W-1:0] FACTORY_ON_SLOTS = 3'h3;

    typedef enum logic [1:0] {
        TT_IDLE,
        TT_ENGAGED,
        TT_HYSTERESIS
    } throttle_state_t;

endpackage : thermal_clock_throttle_pkg

// ==== rtl/thermal_clock_throttle.sv ====
/*
 * Core clock throttle: thermal throttle circuit with hysteresis, on-demand
 * modulation through the clock modulation control register, interrupt latching
 * while clocks are gated.
 * Assumes the trip sensor and force input are asynchronous, and the register
 * port and interrupt request come from logic on the core clock.
 */
`timescale 1ns/100ps

module thermal_clock_throttle #(
    parameter int HYST_CYC = thermal_clock_throttle_pkg::HYST_CYC_DEFAULT
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_thermal_feature_en,
    input wire logic i_die_at_trip,
    input wire logic i_force_throttle_in_n,
    input wire logic i_cmc_wr,
    input wire logic [thermal_clock_throttle_pkg::CMC_WIDTH-1:0] i_cmc_wdata,
    input wire logic i_irq_req,
    input wire logic i_irq_ack,
    output logic [thermal_clock_throttle_pkg::CMC_WIDTH-1:0] o_cmc_rdata,
    output logic o_core_clk_en,
    output logic o_die_hot_indicator_n,
    output logic o_throttle_active,
    output logic o_snoop_en,
    output logic o_irq_pending,
    output logic o_irq_service
);
    import thermal_clock_throttle_pkg::*;

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic trip_s1;
    logic trip_s2;
    logic force_n_s1;
    logic force_n_s2;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            trip_s1 <= 1'b0;
            trip_s2 <= 1'b0;
            force_n_s1 <= 1'b1;
            force_n_s2 <= 1'b1;
        end else begin
            trip_s1 <= i_die_at_trip;
            trip_s2 <= trip_s1;
            force_n_s1 <= i_force_throttle_in_n;
            force_n_s2 <= force_n_s1;
        end
    end

    // Trip point lives in the sensor; nothing here can move or read it
    wire hot = trip_s2;
    // Hardware-only request, no software in the loop
    wire engage_req = i_thermal_feature_en && (hot || !force_n_s2);

    // ---------------------------------------------------------------
    // Clock modulation control register
    // ---------------------------------------------------------------
    logic od_en;
    logic [CMC_DUTY_W-1:0] od_duty;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            od_en <= CMC_RESET[CMC_ENABLE_BIT];
            od_duty <= CMC_RESET[CMC_DUTY_LSB +: CMC_DUTY_W];
        end else if (i_cmc_wr) begin
            od_en <= i_cmc_wdata[CMC_ENABLE_BIT];
            od_duty <= i_cmc_wdata[CMC_DUTY_LSB +: CMC_DUTY_W];
        end
    end

    // Reserved bits read as zero
    wire [CMC_WIDTH-1:0] cmc_view = {{(CMC_WIDTH-CMC_ENABLE_BIT-1){1'b0}}, od_en, od_duty, 1'b0};

    // ---------------------------------------------------------------
    // Throttle state with hysteresis
    // ---------------------------------------------------------------
    throttle_state_t state;
    throttle_state_t next_state;
    logic [$clog2(HYST_CYC+1)-1:0] hyst_cnt;
    wire hyst_done = (hyst_cnt >= ($bits(hyst_cnt))'(HYST_CYC - 1));

    always_comb begin
        next_state = state;
        case (state)
            TT_IDLE: begin
                if (engage_req) next_state = TT_ENGAGED;
            end
            TT_ENGAGED: begin
                if (!engage_req) next_state = TT_HYSTERESIS;
            end
            TT_HYSTERESIS: begin
                if (engage_req) next_state = TT_ENGAGED;
                else if (hyst_done) next_state = TT_IDLE;
            end
            default: next_state = TT_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= TT_IDLE;
            hyst_cnt <= '0;
        end else begin
            state <= next_state;
            hyst_cnt <= (state == TT_HYSTERESIS && !engage_req) ? hyst_cnt + 1'b1 : '0;
        end
    end

    wire tcc_active = (state != TT_IDLE);

    // ---------------------------------------------------------------
    // Modulation timing
    // ---------------------------------------------------------------
    // Slot length keeps seven off slots under the off limit, whatever the duty
    logic [$clog2(SLOT_CYC)-1:0] slot_cnt;
    logic [CMC_DUTY_W-1:0] phase;
    wire slot_end = (slot_cnt == ($bits(slot_cnt))'(SLOT_CYC - 1));

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            slot_cnt <= '0;
            phase <= '0;
        end else begin
            slot_cnt <= slot_end ? '0 : slot_cnt + 1'b1;
            if (slot_end) phase <= phase + 1'b1;
        end
    end

    // Factory duty wins; reserved duty zero leaves clocks running
    wire [CMC_DUTY_W-1:0] on_slots = tcc_active ? FACTORY_ON_SLOTS : od_duty;
    wire od_mod = od_en && (od_duty != DUTY_RESERVED);
    wire mod_active = tcc_active || od_mod;
    // k eighths on per period of eight slots
    wire next_clk_en = !mod_active || (phase < on_slots);

    // ---------------------------------------------------------------
    // Interrupt latch and outputs
    // ---------------------------------------------------------------
    // Set wins over acknowledge so a request in the ack cycle is kept
    wire next_pending = i_irq_req || (o_irq_pending && !i_irq_ack);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_cmc_rdata <= CMC_RESET;
            o_core_clk_en <= 1'b1;
            o_die_hot_indicator_n <= 1'b1;
            o_throttle_active <= 1'b0;
            o_snoop_en <= 1'b0;
            o_irq_pending <= 1'b0;
            o_irq_service <= 1'b0;
        end else begin
            o_cmc_rdata <= cmc_view;
            o_core_clk_en <= next_clk_en;
            o_die_hot_indicator_n <= !hot;
            o_throttle_active <= tcc_active;
            o_snoop_en <= 1'b1;
            o_irq_pending <= next_pending;
            o_irq_service <= next_pending && next_clk_en;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    logic [$clog2(MAX_OFF_CYC+2)-1:0] off_run;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) off_run <= '0;
        else off_run <= o_core_clk_en ? '0 : off_run + 1'b1;
    end

    property p_hot_engage;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_thermal_feature_en && hot) |=> tcc_active ##1 o_throttle_active;
    endproperty
    a_hot_engage: assert property (p_hot_engage) else $error("Throttle not engaged when hot");

    property p_hot_pin;
        @(posedge i_sys_clk) disable iff (i_rst)
        hot |=> !o_die_hot_indicator_n;
    endproperty
    a_hot_pin: assert property (p_hot_pin) else $error("Hot indicator not driven");

    property p_force;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_thermal_feature_en && !force_n_s2) |=> tcc_active;
    endproperty
    a_force: assert property (p_force) else $error("Force input did not engage throttle");

    property p_off_limit;
        @(posedge i_sys_clk) disable iff (i_rst)
        off_run <= ($bits(off_run))'(MAX_OFF_CYC);
    endproperty
    a_off_limit: assert property (p_off_limit) else $error("Clock off longer than limit");

    property p_release;
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(tcc_active) |-> $past(!engage_req) && $past(hyst_done) && $past(state == TT_HYSTERESIS);
    endproperty
    a_release: assert property (p_release) else $error("Released before hysteresis");

    property p_factory_duty;
        @(posedge i_sys_clk) disable iff (i_rst)
        tcc_active |=> (o_core_clk_en == ($past(phase) < FACTORY_ON_SLOTS));
    endproperty
    a_factory_duty: assert property (p_factory_duty) else $error("Factory duty not applied");

    property p_od_start;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_cmc_wr && i_cmc_wdata[CMC_ENABLE_BIT]) |=> od_en ##1 o_cmc_rdata[CMC_ENABLE_BIT];
    endproperty
    a_od_start: assert property (p_od_start) else $error("On-demand enable not taken");

    property p_duty_field;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_cmc_wr |=> (od_duty == $past(i_cmc_wdata[CMC_DUTY_LSB +: CMC_DUTY_W]));
    endproperty
    a_duty_field: assert property (p_duty_field) else $error("Duty field not stored");

    property p_irq_gate;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_irq_req || (o_irq_pending && !i_irq_ack)) |=> o_irq_pending && (o_irq_service == o_core_clk_en);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Interrupt serviced with clocks off");

    c_engage: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(tcc_active));
    c_release: cover property (@(posedge i_sys_clk) disable iff (i_rst) $fell(tcc_active));
    c_od_gate: cover property (@(posedge i_sys_clk) disable iff (i_rst) od_mod && !tcc_active && !o_core_clk_en);
    c_irq_wait: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_irq_pending && !o_core_clk_en);

endmodule : thermal_clock_throttle

// ==== bench/thermal_platform_model.sv ====
/*
 * Platform side of the throttle: force-throttle driver and core clock tree
 * watcher that records the longest run of gated clock cycles.
 * Assumes the bench asks for a force pulse with a one-cycle request.
 */
`timescale 1ns/100ps
module thermal_platform_model
    import thermal_clock_throttle_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_force_req,
    input wire logic i_core_clk_en,
    output logic o_force_throttle_in_n,
    output int o_max_off
);
    int hold = 0;
    int off_run = 0;
    // Pulse held for the full minimum width; shorter pulses are never sent
    always @(posedge i_sys_clk) begin
        if (i_force_req) hold <= FORCE_MIN_CYC;
        else if (hold != 0) hold <= hold - 1;
    end
    assign o_force_throttle_in_n = (hold == 0) && !i_force_req;
    initial o_max_off = 0;
    always @(posedge i_sys_clk) begin
        off_run = i_core_clk_en ? 0 : off_run + 1;
        if (off_run > o_max_off) o_max_off = off_run;
    end
endmodule : thermal_platform_model

// ==== bench/thermal_clock_throttle_tb.sv ====
/*
 * Self-checking bench for the core clock throttle with a behavioural duty model.
 * Assumes the platform model in the bench folder and a shortened hysteresis.
 */
`timescale 1ns/100ps
module thermal_clock_throttle_tb;
    import thermal_clock_throttle_pkg::*;
    localparam int HYST = 20;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic feat_en = 1'b1;
    logic trip = 1'b0;
    logic force_req = 1'b0;
    logic force_n;
    logic cmc_wr = 1'b0;
    logic [63:0] cmc_wdata = 64'h0000_0000_0000_0000;
    logic irq_req = 1'b0;
    logic irq_ack = 1'b0;
    logic [63:0] rdata;
    logic clk_en, hot_n, thr, snoop, pend, svc;
    int max_off;
    int num_errors = 0;
    int svc_seen = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [63:0] d;
    always #20 i_sys_clk = ~i_sys_clk;
    thermal_clock_throttle #(.HYST_CYC(HYST)) dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_thermal_feature_en(feat_en), .i_die_at_trip(trip), .i_force_throttle_in_n(force_n),
        .i_cmc_wr(cmc_wr), .i_cmc_wdata(cmc_wdata), .i_irq_req(irq_req), .i_irq_ack(irq_ack),
        .o_cmc_rdata(rdata), .o_core_clk_en(clk_en), .o_die_hot_indicator_n(hot_n),
        .o_throttle_active(thr), .o_snoop_en(snoop), .o_irq_pending(pend), .o_irq_service(svc));
    thermal_platform_model plat_u (.i_sys_clk(i_sys_clk), .i_force_req(force_req),
        .i_core_clk_en(clk_en), .o_force_throttle_in_n(force_n), .o_max_off(max_off));
    // ---------------------------------------------------------------
    // Reference model and helpers
    // ---------------------------------------------------------------
    // Whole-period window: the free-running phase makes any 72-cycle count exact
    function automatic int exp_slots(input int eng, input int od, input int duty);
        if (eng != 0) return int'(FACTORY_ON_SLOTS);
        return (od != 0 && duty != 0) ? duty : MOD_SLOTS;
    endfunction : exp_slots
    task automatic report_and_stop();
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : step
    task automatic wr_cmc(input logic [63:0] v);
        cmc_wr = 1'b1;
        cmc_wdata = v;
        step(1);
        cmc_wr = 1'b0;
    endtask : wr_cmc
    task automatic wait_thr(input logic v, input int lim);
        int n;
        n = 0;
        while (thr !== v && n < lim) begin
            step(1);
            n++;
        end
        chk("throttle_active", {63'h0, v}, {63'h0, thr});
    endtask : wait_thr
    task automatic meas(input int slots);
        int on;
        int sv;
        on = 0;
        sv = 0;
        repeat (MOD_SLOTS * SLOT_CYC) begin
            step(1);
            on += int'(clk_en === 1'b1);
            sv += int'(svc === 1'b1);
        end
        chk("clk_on_cycles", 64'(slots * SLOT_CYC), 64'(on));
        svc_seen = sv;
    endtask : meas
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(37));
        step(2);
        i_rst = 1'b0;
        step(2);
        chk("cmc_rdata", 64'h0000_0000_0000_0000, rdata);
        chk("state", 64'h0000_0000_0000_001a, {59'h0, clk_en, hot_n, thr, snoop, pend});
        for (int k = 0; k < 8; k++) begin
            d = ({$urandom(), $urandom()} & ~64'h0000_0000_0000_001e) | 64'h0000_0000_0000_0010 | 64'(k << 1);
            wr_cmc(d);
            step(2);
            chk("cmc_rdata", d & 64'h0000_0000_0000_001e, rdata);
            step(80);
            meas(exp_slots(0, 1, k));
        end
        wr_cmc(64'h0000_0000_0000_001e);
        // Temperature limits are left to the hardware throttle, not to on-demand
        trip = 1'b1;
        wait_thr(1'b1, 10);
        chk("hot_n", 64'h0, {63'h0, hot_n});
        step(80);
        meas(exp_slots(1, 1, 7));
        irq_req = 1'b1;
        step(1);
        irq_req = 1'b0;
        meas(exp_slots(1, 1, 7));
        chk("irq_pending", 64'h1, {63'h0, pend});
        chk("irq_serviced", 64'(int'(FACTORY_ON_SLOTS) * SLOT_CYC), 64'(svc_seen));
        chk("snoop_en", 64'h1, {63'h0, snoop});
        irq_ack = 1'b1;
        step(1);
        irq_ack = 1'b0;
        step(2);
        chk("irq_pending", 64'h0, {63'h0, pend});
        irq_req = 1'b1;
        irq_ack = 1'b1;
        step(1);
        irq_req = 1'b0;
        irq_ack = 1'b0;
        step(1);
        chk("irq_set_wins", 64'h1, {63'h0, pend});
        irq_ack = 1'b1;
        step(1);
        irq_ack = 1'b0;
        trip = 1'b0;
        step(HYST);
        chk("throttle_held", 64'h1, {63'h0, thr});
        wait_thr(1'b0, 15);
        step(80);
        meas(exp_slots(0, 1, 7));
        chk("cmc_rdata", 64'h0000_0000_0000_001e, rdata);
        wr_cmc(64'h0000_0000_0000_0000);
        feat_en = 1'b0;
        trip = 1'b1;
        step(10);
        chk("disabled", 64'h0, {62'h0, thr, hot_n});
        meas(exp_slots(0, 0, 0));
        trip = 1'b0;
        // Let the trip drain from the synchroniser first, or the force test proves nothing
        step(3);
        feat_en = 1'b1;
        step(5);
        chk("throttle_idle", 64'h0, {63'h0, thr});
        force_req = 1'b1;
        step(1);
        force_req = 1'b0;
        wait_thr(1'b1, 10);
        chk("hot_n_forced", 64'h1, {63'h0, hot_n});
        step(80);
        meas(exp_slots(1, 0, 0));
        wait_thr(1'b0, FORCE_MIN_CYC + HYST + 20);
        chk("max_off_ok", 64'h1, {63'h0, max_off <= MAX_OFF_CYC});
        report_and_stop();
    end
endmodule : thermal_clock_throttle_tb
